/* File: verilog/i2c_baud_status.sv */
// Purpose: i2c baud rate generator and bus status registers on AHB-Lite
// Assumes: controller core supplies phase levels and event pulses on mclk
// Notes:   diagnostic select sits in its own word, see the register map
//
// Local design decision: the AHB-Lite interface to the registers.
`timescale 1ns/100ps
module i2c_baud_status #(
	parameter int RELOAD_WIDTH = 16
) (
	input  wire logic        mclk,
	input  wire logic        srst,
	// AHB-Lite slave
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic        hready,
	input  wire logic [31:0] hwdata,
	output logic             hreadyout,
	output logic             hresp,
	output logic [31:0]      hrdata,
	// controller core side
	input  wire logic        baudRun,
	input  wire logic        txActive,
	input  wire logic        txByteStart,
	input  wire logic        ackSampled,
	input  wire logic        ackIn,
	input  wire logic        addrPhase,
	input  wire logic        dataPhase,
	input  wire logic        startReq,
	input  wire logic [4:0]  addrTop,
	input  wire logic        addrSent,
	input  wire logic        stopRestartEvt,
	input  wire logic        isRestart,
	input  wire logic        busBusy,
	input  wire logic [7:0]  ctrlState,
	output logic             baudTick,
	output logic             sclDrive,
	output logic             diagnosticSelect
);
	// all state of the register block
	typedef struct packed {
		logic [7:0] reloadHigh; // upper reload byte
		logic [7:0] reloadLow;  // lower reload byte
		logic       diagnostic_select;       // diagnostic select
		logic       ackValid;   // ack reflects last sent byte
		logic       ackBit;     // last ack seen
		logic       addrFlag;   // address byte on the bus
		logic       dataFlag;   // data byte on the bus
		logic       tenBit;     // ten-bit address in flight
		logic       restart;    // last end was a restart
	} regs_t;

	regs_t stR;  // registered state
	regs_t stNxt; // next state

	logic [RELOAD_WIDTH-1:0] reloadValue; // combined reload
	logic [RELOAD_WIDTH-1:0] counter;     // live baud counter
	logic                    wrStrobe;    // write in data phase
	logic [29:0]             regIndex;    // latched register index
	logic [7:0]              rdData;      // read mux result
	logic [7:0]              statusWord;  // packed status flags
	logic                    ackSet;      // sent-byte ack captured
	logic                    ackClr;      // next byte or end of transfer
	logic                    tenSet;      // ten-bit prefix seen

	// reload bytes joined high over low
	assign reloadValue = {stR.reloadHigh, stR.reloadLow};

	// bus slave front end
	ahb_reg_port u_port (
		.mclk      (mclk),
		.srst      (srst),
		.hsel      (hsel),
		.haddr     (haddr),
		.htrans    (htrans),
		.hwrite    (hwrite),
		.hsize     (hsize),
		.hready    (hready),
		.rdData    (rdData),
		.hreadyout (hreadyout),
		.hresp     (hresp),
		.hrdata    (hrdata),
		.wrStrobe  (wrStrobe),
		.regIndex  (regIndex)
	);

	// serial clock pacing
	baud_counter #(
		.WIDTH (RELOAD_WIDTH)
	) u_baud (
		.mclk        (mclk),
		.srst        (srst),
		.run         (baudRun),
		.reloadValue (reloadValue),
		.count       (counter),
		.tick        (baudTick),
		.driven_clock_level      (sclDrive)
	);

	// event qualifiers
	assign ackSet = ackSampled && txActive;
	assign ackClr = txByteStart || stopRestartEvt;
	assign tenSet = startReq && (addrTop == i2c_status_pkg::TEN_BIT_PREFIX);

	// status flags gathered in bit order
	always_comb begin
		statusWord                               = 8'h00;
		statusWord[i2c_status_pkg::ST_ACK_VALID]  = stR.ackValid;
		statusWord[i2c_status_pkg::ST_ACK]        = stR.ackBit;
		statusWord[i2c_status_pkg::ST_ADDR_PHASE] = stR.addrFlag;
		statusWord[i2c_status_pkg::ST_DATA_PHASE] = stR.dataFlag;
		statusWord[i2c_status_pkg::ST_TEN_BIT]    = stR.tenBit;
		statusWord[i2c_status_pkg::ST_RESTART]    = stR.restart;
		// driven level, not the sampled pin
		statusWord[i2c_status_pkg::ST_SCL_OUT]    = sclDrive;
		statusWord[i2c_status_pkg::ST_BUSY]       = busBusy;
	end

	// read mux; unmapped words read as zero
	always_comb begin
		rdData = 8'h00;
		unique case (regIndex)
			i2c_status_pkg::IDX_RELOAD_HIGH: begin
				// diagnostic view shows the running count
				rdData = stR.diagnostic_select ? counter[15:8] : stR.reloadHigh;
			end
			i2c_status_pkg::IDX_RELOAD_LOW: begin
				rdData = stR.diagnostic_select ? counter[7:0] : stR.reloadLow;
			end
			i2c_status_pkg::IDX_BUS_STATUS: begin
				rdData = stR.diagnostic_select ? ctrlState : statusWord;
			end
			i2c_status_pkg::IDX_DIAGNOSTIC_SELECT_CTRL: begin
				rdData = {7'h00, stR.diagnostic_select};
			end
			default: begin
				rdData = 8'h00;
			end
		endcase
	end

	// next state of the register block
	always_comb begin
		stNxt = stR;
		// software writes; status has no write path
		if (wrStrobe) begin
			unique case (regIndex)
				i2c_status_pkg::IDX_RELOAD_HIGH: begin
					stNxt.reloadHigh = hwdata[7:0];
				end
				i2c_status_pkg::IDX_RELOAD_LOW: begin
					stNxt.reloadLow = hwdata[7:0];
				end
				i2c_status_pkg::IDX_DIAGNOSTIC_SELECT_CTRL: begin
					stNxt.diagnostic_select = hwdata[0];
				end
				default: begin
					// read-only or unmapped, write dropped
				end
			endcase
		end
		// clear first so a same-cycle set wins
		if (ackClr) begin
			stNxt.ackValid = 1'h0;
		end
		if (ackSet) begin
			stNxt.ackValid = 1'h1;
		end
		// ack level of any byte, sent or received
		if (ackSampled) begin
			stNxt.ackBit = ackIn;
		end
		// phase flags follow the controller, one cycle late
		stNxt.addrFlag = addrPhase;
		stNxt.dataFlag = dataPhase;
		// ten-bit flag, set beats the address-sent clear
		if (addrSent) begin
			stNxt.tenBit = 1'h0;
		end
		if (tenSet) begin
			stNxt.tenBit = 1'h1;
		end
		// stop versus restart on every end event
		if (stopRestartEvt) begin
			stNxt.restart = isRestart;
		end
	end

	// state register, reloads come up all ones
	always_ff @(posedge mclk) begin
		if (srst) begin
			stR            <= '0;
			stR.reloadHigh <= i2c_status_pkg::RELOAD_RESET;
			stR.reloadLow  <= i2c_status_pkg::RELOAD_RESET;
		end else begin
			stR <= stNxt;
		end
	end

	assign diagnosticSelect = stR.diagnostic_select;

	// checks on the register block
	default clocking cb @(posedge mclk); endclocking
	default disable iff (srst);

	// a read of the status word being accepted
	sequence s_rdStatus;
		hsel && hready && (htrans == i2c_status_pkg::HTRANS_NONSEQ) && !hwrite &&
			(haddr[31:2] == i2c_status_pkg::IDX_BUS_STATUS);
	endsequence

	// a write of the high reload byte being accepted
	sequence s_wrHigh;
		hsel && hready && (htrans == i2c_status_pkg::HTRANS_NONSEQ) && hwrite &&
			(haddr[31:2] == i2c_status_pkg::IDX_RELOAD_HIGH);
	endsequence

	// a write of the low reload byte being accepted
	sequence s_wrLow;
		hsel && hready && (htrans == i2c_status_pkg::HTRANS_NONSEQ) && hwrite &&
			(haddr[31:2] == i2c_status_pkg::IDX_RELOAD_LOW);
	endsequence

	// a read of the high reload byte being accepted
	sequence s_rdHigh;
		hsel && hready && (htrans == i2c_status_pkg::HTRANS_NONSEQ) && !hwrite &&
			(haddr[31:2] == i2c_status_pkg::IDX_RELOAD_HIGH);
	endsequence

	// a read of the low reload byte being accepted
	sequence s_rdLow;
		hsel && hready && (htrans == i2c_status_pkg::HTRANS_NONSEQ) && !hwrite &&
			(haddr[31:2] == i2c_status_pkg::IDX_RELOAD_LOW);
	endsequence

	a_ack_set: assert property (
		ackSet |=> stR.ackValid)
		else $error("ack valid not set after sent byte");

	a_ack_clear: assert property (
		ackClr && !ackSet |=> !stR.ackValid)
		else $error("ack valid not cleared");

	a_ack_level: assert property (
		ackSampled |=> stR.ackBit == $past(ackIn))
		else $error("ack bit does not match sampled ack");

	a_ten_bit: assert property (
		tenSet ##1 !addrSent |-> stR.tenBit ##1 stR.tenBit)
		else $error("ten-bit flag lost before address sent");

	a_ten_clear: assert property (
		addrSent && !tenSet |=> !stR.tenBit)
		else $error("ten-bit flag not cleared after address");

	a_restart_kind: assert property (
		stopRestartEvt |=> stR.restart == $past(isRestart))
		else $error("restart flag not updated");

	a_status_read: assert property (
		s_rdStatus ##1 1'h1 |=> hreadyout &&
			hrdata[7:0] == ($past(stR.diagnostic_select) ? $past(ctrlState) : $past(statusWord)))
		else $error("status read returned wrong view");

	a_reload_write: assert property (
		s_wrHigh ##2 hreadyout |-> stR.reloadHigh == $past(hwdata[7:0]))
		else $error("high reload byte not written");

	a_phase_flags: assert property (
		addrPhase && dataPhase == 1'h0 |=> stR.addrFlag && !stR.dataFlag)
		else $error("phase flags do not follow controller");

	a_reload_rst: assert property (
		$rose(!srst) |-> reloadValue == {2{i2c_status_pkg::RELOAD_RESET}})
		else $error("reload value not all ones after reset");

	// low byte lands at the end of its wait cycle
	a_low_write: assert property (
		s_wrLow ##2 hreadyout |-> stR.reloadLow == $past(hwdata[7:0]))
		else $error("low reload byte not written");

	// view taken in the wait cycle, shown once the data phase ends
	a_diagnostic_select_high: assert property (
		s_rdHigh ##1 1'h1 |=> hrdata[7:0] ==
			($past(stR.diagnostic_select) ? $past(counter[15:8]) : $past(stR.reloadHigh)))
		else $error("high reload read returned wrong view");

	// same for the low byte, counter low half under diagnostics
	a_diagnostic_select_low: assert property (
		s_rdLow ##1 1'h1 |=> hrdata[7:0] ==
			($past(stR.diagnostic_select) ? $past(counter[7:0]) : $past(stR.reloadLow)))
		else $error("low reload read returned wrong view");

	// data byte on the bus shows only the data flag
	a_data_flag: assert property (
		dataPhase && !addrPhase |=> stR.dataFlag && !stR.addrFlag)
		else $error("data flag does not follow controller");

	// both phase flags drop when no byte is on the bus
	a_flags_idle: assert property (
		!addrPhase && !dataPhase |=> !stR.addrFlag && !stR.dataFlag)
		else $error("phase flag stuck high");

	// a received byte's ack must not touch ack valid
	a_ack_receive: assert property (
		ackSampled && !txActive && !ackClr |=> stR.ackValid == $past(stR.ackValid))
		else $error("ack valid moved on a received byte");

	// restart kind only changes on an end event
	a_restart_hold: assert property (
		!stopRestartEvt |=> $stable(stR.restart))
		else $error("restart flag moved without an end event");

	// ack level only changes when an ack is sampled
	a_ack_hold: assert property (
		!ackSampled |=> $stable(stR.ackBit))
		else $error("ack bit moved without a sampled ack");

	// stop or restart ends the transfer, ack valid drops
	a_stop_clear: assert property (
		stopRestartEvt && !ackSet |=> !stR.ackValid)
		else $error("ack valid not cleared by stop or restart");
endmodule : i2c_baud_status

/* File: verilog/i2c_status_pkg.sv */
// Purpose: shared constants for the i2c baud generator and bus status block
// Assumes: AHB-Lite word access, register index times four is the byte address
// Notes:   reload reset value and field positions live here only
package i2c_status_pkg;
	// register indices, byte address is index * 4
	localparam logic [29:0] IDX_RELOAD_HIGH = 30'h00FFE243;
	localparam logic [29:0] IDX_RELOAD_LOW  = 30'h00FFE244;
	localparam logic [29:0] IDX_BUS_STATUS  = 30'h00FFE245;
	localparam logic [29:0] IDX_DIAGNOSTIC_SELECT_CTRL   = 30'h00FFE24F; // diagnostic select word

	// reset values
	localparam logic [7:0]  RELOAD_RESET    = 8'hFF;
	localparam logic [7:0]  FLAGS_RESET     = 8'h00;

	// status field positions
	localparam int          ST_ACK_VALID    = 7;
	localparam int          ST_ACK          = 6;
	localparam int          ST_ADDR_PHASE   = 5;
	localparam int          ST_DATA_PHASE   = 4;
	localparam int          ST_TEN_BIT      = 3;
	localparam int          ST_RESTART      = 2;
	localparam int          ST_SCL_OUT      = 1;
	localparam int          ST_BUSY         = 0;

	// top five address bits that mark ten-bit addressing
	localparam logic [4:0]  TEN_BIT_PREFIX  = 5'h1E;

	// half bit value on which a tick flips the serial clock, two counter periods per half
	localparam logic        HALF_PERIODS    = 1'h1;

	// AHB transfer type
	localparam logic [1:0]  HTRANS_NONSEQ   = 2'h2;

	// bus slave states
	typedef enum logic [1:0] {PORT_IDLE, PORT_WAIT, PORT_DONE} portState_t;
endpackage : i2c_status_pkg

/* File: verilog/ahb_reg_port.sv */
// Purpose: AHB-Lite slave front end with one wait state per transfer
// Assumes: single word transfers only, response always OKAY
// Notes:   read data is registered, so every transfer answers on the second edge
`timescale 1ns/100ps
module ahb_reg_port (
	input  wire logic        mclk,
	input  wire logic        srst,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic        hready,
	input  wire logic [7:0]  rdData,
	output logic             hreadyout,
	output logic             hresp,
	output logic [31:0]      hrdata,
	output logic             wrStrobe,
	output logic [29:0]      regIndex
);
	// all state of the port
	typedef struct packed {
		i2c_status_pkg::portState_t phase;
		logic                       isWrite;
		logic [29:0]                index;
		logic [31:0]                rdWord;
	} port_t;

	port_t stR;  // registered state
	port_t stNxt; // next state

	logic  take; // address phase accepted

	// next-state logic; hsize is not checked since only words are issued
	always_comb begin
		stNxt = stR;
		take  = hsel && hready && (htrans == i2c_status_pkg::HTRANS_NONSEQ);
		unique case (stR.phase)
			i2c_status_pkg::PORT_WAIT: begin
				// capture read data while the address is stable
				stNxt.rdWord = {24'h000000, rdData};
				stNxt.phase  = i2c_status_pkg::PORT_DONE;
			end
			i2c_status_pkg::PORT_IDLE,
			i2c_status_pkg::PORT_DONE: begin
				stNxt.phase = i2c_status_pkg::PORT_IDLE;
				if (take) begin
					stNxt.phase   = i2c_status_pkg::PORT_WAIT;
					stNxt.isWrite = hwrite;
					stNxt.index   = haddr[31:2];
				end
			end
		endcase
	end

	// state register
	always_ff @(posedge mclk) begin
		if (srst) begin
			stR <= '0;
		end else begin
			stR <= stNxt;
		end
	end

	assign hreadyout = (stR.phase != i2c_status_pkg::PORT_WAIT);
	assign hresp     = 1'h0;
	assign hrdata    = stR.rdWord;
	assign wrStrobe  = (stR.phase == i2c_status_pkg::PORT_WAIT) && stR.isWrite;
	assign regIndex  = stR.index;
endmodule : ahb_reg_port

/* File: verilog/baud_counter.sv */
// Purpose: down counter that paces the serial clock
// Assumes: run is a level from the controller, high while the clock is needed
// Notes:   a reload of zero wraps through all ones, giving a full 65536 count
`timescale 1ns/100ps
module baud_counter #(
	parameter int WIDTH = 16
) (
	input  wire logic             mclk,
	input  wire logic             srst,
	input  wire logic             run,
	input  wire logic [WIDTH-1:0] reloadValue,
	output logic      [WIDTH-1:0] count,
	output logic                  tick,
	output logic                  driven_clock_level
);
	// all state of the counter
	typedef struct packed {
		logic [WIDTH-1:0] cnt;
		logic             half;
		logic             scl;
	} baud_t;

	baud_t stR;  // registered state
	baud_t stNxt; // next state

	localparam logic [WIDTH-1:0] ONE = WIDTH'(1);

	// count down, reload at one; two periods per half clock
	always_comb begin
		stNxt = stR;
		tick  = run && (stR.cnt == ONE);
		if (!run) begin
			// released clock sits high while idle
			stNxt.cnt  = reloadValue;
			stNxt.half = 1'h0;
			stNxt.scl  = 1'h1;
		end else if (tick) begin
			stNxt.cnt  = reloadValue;
			stNxt.half = ~stR.half;
			if (stR.half == i2c_status_pkg::HALF_PERIODS) begin
				stNxt.scl = ~stR.scl;
			end
		end else begin
			stNxt.cnt = stR.cnt - ONE;
		end
	end

	// state register
	always_ff @(posedge mclk) begin
		if (srst) begin
			stR <= '{cnt: '1, half: 1'h0, scl: 1'h1};
		end else begin
			stR <= stNxt;
		end
	end

	assign count  = stR.cnt;
	assign driven_clock_level = stR.scl;

	default clocking cb @(posedge mclk); endclocking
	default disable iff (srst);

	a_reload_at_one: assert property (
		tick |=> stR.cnt == $past(reloadValue))
		else $error("counter did not reload at terminal count");

	a_scl_steady: assert property (
		run && !tick && $past(run) |=> $stable(stR.scl))
		else $error("serial clock moved between ticks");
endmodule : baud_counter

/* File: dv/core_side_model.sv */
// Purpose: stand-in for the controller core that feeds the status block
// Assumes: strobes last one mclk cycle and their qualifiers ride with them
// Notes:   qualifiers flip once released, so a stale level never reads as valid
`timescale 1ns/100ps
module core_side_model (
	input  wire logic mclk,
	output logic      baudRun,
	output logic      txActive,
	output logic      txByteStart,
	output logic      ackSampled,
	output logic      ackIn,
	output logic      addrPhase,
	output logic      dataPhase,
	output logic      startReq,
	output logic [4:0] addrTop,
	output logic      addrSent,
	output logic      stopRestartEvt,
	output logic      isRestart,
	output logic      busBusy,
	output logic [7:0] ctrlState
);
	// quiet core: no transfer, generator parked
	initial begin
		{baudRun, txActive, txByteStart, ackSampled, ackIn, addrPhase, dataPhase} = '0;
		{startReq, addrTop, addrSent, stopRestartEvt, isRestart, busBusy, ctrlState} = '0;
	end

	// one-cycle event: 0 next byte, 1 ack seen, 2 start, 3 address done, 4 stop/restart
	task automatic pulse(input int kind, input logic q, input logic [4:0] top);
		@(posedge mclk);
		case (kind)
			0: txByteStart <= 1'b1;
			1: begin
				ackSampled <= 1'b1;
				ackIn      <= q;
			end
			2: begin
				startReq <= 1'b1;
				addrTop  <= top;
			end
			3: addrSent <= 1'b1;
			default: begin
				stopRestartEvt <= 1'b1;
				isRestart      <= q;
			end
		endcase
		@(posedge mclk);
		{txByteStart, ackSampled, startReq, addrSent, stopRestartEvt} <= '0;
		ackIn     <= ~q;
		isRestart <= ~q;
		addrTop   <= ~top;
	endtask : pulse
endmodule : core_side_model

/* File: dv/i2c_baud_status_test.sv */
// Purpose: self-checking bench for the baud generator and bus status block
// Assumes: one AHB-Lite slave, so hready is the block's own hreadyout
// Notes:   ready and data are sampled at the falling edge before each rising edge
`timescale 1ns/100ps
module i2c_baud_status_test;
	localparam logic [29:0] HI = i2c_status_pkg::IDX_RELOAD_HIGH;
	localparam logic [29:0] LO = i2c_status_pkg::IDX_RELOAD_LOW;
	localparam logic [29:0] ST = i2c_status_pkg::IDX_BUS_STATUS;
	localparam logic [29:0] DG = i2c_status_pkg::IDX_DIAGNOSTIC_SELECT_CTRL;
	logic        mclk = 1'b0;  // 40 MHz system clock
	logic        srst;         // synchronous reset
	logic        hsel, hwrite, hreadyout, hresp;
	logic [1:0]  htrans;
	logic [31:0] haddr, hwdata, hrdata;
	logic        baudRun, txActive, txByteStart, ackSampled, ackIn, addrPhase, dataPhase;
	logic        startReq, addrSent, stopRestartEvt, isRestart, busBusy;
	logic [4:0]  addrTop;
	logic [7:0]  ctrlState;
	logic        baudTick, sclDrive, diagSel;
	int          nErrors = 0;     // mismatches
	int          totalChecks = 0; // comparisons made
	int          cycles = 0;      // hang guard

	always #12.5 mclk = ~mclk;

	i2c_baud_status u_dut (.mclk, .srst, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2),
		.hready(hreadyout), .hwdata, .hreadyout, .hresp, .hrdata, .baudRun, .txActive,
		.txByteStart, .ackSampled, .ackIn, .addrPhase, .dataPhase, .startReq, .addrTop,
		.addrSent, .stopRestartEvt, .isRestart, .busBusy, .ctrlState, .baudTick, .sclDrive,
		.diagnosticSelect(diagSel));

	core_side_model u_core (.mclk, .baudRun, .txActive, .txByteStart, .ackSampled, .ackIn,
		.addrPhase, .dataPhase, .startReq, .addrTop, .addrSent, .stopRestartEvt, .isRestart,
		.busBusy, .ctrlState);

	task automatic chk(input logic [31:0] exp, input logic [31:0] got, input string what);
		totalChecks++;
		if (got !== exp) begin
			nErrors++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	// single word transfer; callers enter just after a rising edge
	task automatic bus(input logic wr, input logic [29:0] idx, input logic [31:0] wd,
		output logic [31:0] rd);
		hsel   <= 1'b1;
		htrans <= i2c_status_pkg::HTRANS_NONSEQ;
		haddr  <= {idx, 2'h0};
		hwrite <= wr;
		do @(negedge mclk); while (hreadyout !== 1'b1);
		@(posedge mclk);
		hsel   <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		do @(negedge mclk); while (hreadyout !== 1'b1);
		rd = hrdata;
		@(posedge mclk);
	endtask : bus

	task automatic wr(input logic [29:0] idx, input logic [7:0] d);
		logic [31:0] rd;
		bus(1'b1, idx, {24'h0, d}, rd);
	endtask : wr

	task automatic rdc(input logic [29:0] idx, input logic [7:0] exp, input string what);
		logic [31:0] rd;
		bus(1'b0, idx, 32'h0, rd);
		chk({24'h0, exp}, rd, what);
		chk(32'h0, {31'h0, hresp}, "hresp");
	endtask : rdc

	// cycles from one tick to the next
	task automatic tick_gap(output int g);
		while (baudTick !== 1'b1) @(negedge mclk);
		g = 0;
		do begin
			@(negedge mclk);
			g++;
		end while (baudTick !== 1'b1 && g < 70000);
	endtask : tick_gap

	task automatic t_baud();
		int g;
		int n;
		logic s;
		wr(HI, 8'h00);
		wr(LO, 8'h03);
		u_core.baudRun <= 1'b1;
		tick_gap(g);
		chk(32'd3, g, "tick gap");
		@(negedge mclk);
		s = sclDrive;
		do @(negedge mclk); while (sclDrive === s);
		s = sclDrive;
		g = 0;
		do begin
			@(negedge mclk);
			g++;
		end while (sclDrive === s && g < 99);
		chk(32'd6, g, "scl half period");
		@(posedge mclk);
		wr(LO, 8'h00);
		n = 0;
		do begin
			tick_gap(g);
			n++;
		end while (g == 3 && n < 5);
		chk(32'd65536, g, "zero reload gap");
		@(posedge mclk);
		u_core.baudRun <= 1'b0;
		$display("test baud done");
	endtask : t_baud

	task automatic t_diagnostic_select();
		wr(HI, 8'h02);
		wr(LO, 8'h00);
		wr(DG, 8'h01);
		chk(32'h1, {31'h0, diagSel}, "diagnostic_select select");
		u_core.ctrlState <= 8'hC7;
		rdc(ST, 8'hC7, "state code");
		u_core.baudRun <= 1'b1;
		repeat (300) @(posedge mclk);
		// 0x200 less 301 edges by the read's wait cycle
		rdc(LO, 8'hD3, "counter low");
		rdc(HI, 8'h00, "counter high");
		u_core.baudRun <= 1'b0;
		wr(DG, 8'h00);
		rdc(HI, 8'h02, "reload high");
		$display("test diagnostic_select done");
	endtask : t_diagnostic_select

	task automatic t_flags();
		u_core.txActive <= 1'b1;
		u_core.pulse(1, 1'b1, 5'h00);
		rdc(ST, 8'hC2, "ack valid set");
		u_core.pulse(0, 1'b0, 5'h00);
		rdc(ST, 8'h42, "next byte clears");
		u_core.pulse(1, 1'b0, 5'h00);
		rdc(ST, 8'h82, "nack");
		u_core.pulse(4, 1'b1, 5'h00);
		rdc(ST, 8'h06, "restart");
		u_core.pulse(4, 1'b0, 5'h00);
		rdc(ST, 8'h02, "stop");
		u_core.txActive <= 1'b0;
		u_core.pulse(1, 1'b1, 5'h00);
		rdc(ST, 8'h42, "receive ack");
		u_core.addrPhase <= 1'b1;
		u_core.busBusy   <= 1'b1;
		rdc(ST, 8'h63, "address phase");
		u_core.addrPhase <= 1'b0;
		u_core.dataPhase <= 1'b1;
		rdc(ST, 8'h53, "data phase");
		u_core.dataPhase <= 1'b0;
		u_core.busBusy   <= 1'b0;
		u_core.pulse(2, 1'b0, 5'h1E);
		rdc(ST, 8'h4A, "ten bit set");
		u_core.pulse(3, 1'b0, 5'h00);
		rdc(ST, 8'h42, "ten bit cleared");
		u_core.pulse(2, 1'b0, 5'h0E);
		rdc(ST, 8'h42, "seven bit");
		$display("test flags done");
	endtask : t_flags

	task automatic complete_run();
		$display("checks %0d errors %0d", totalChecks, nErrors);
		if (nErrors == 0 && totalChecks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : complete_run

	// cut a hang short well past the longest expected run
	always @(posedge mclk) begin
		cycles <= cycles + 1;
		if (cycles == 90000) begin
			nErrors++;
			complete_run();
		end
	end

	initial begin
		{srst, hsel, haddr, htrans, hwrite, hwdata} = {1'b1, 68'h0};
		repeat (20) @(posedge mclk);
		srst <= 1'b0;
		@(posedge mclk);
		rdc(HI, 8'hFF, "reset reload high");
		rdc(LO, 8'hFF, "reset reload low");
		rdc(ST, 8'h02, "reset status");
		wr(HI, 8'hA5);
		wr(LO, 8'h3C);
		wr(ST, 8'hFF);
		rdc(HI, 8'hA5, "reload high");
		rdc(LO, 8'h3C, "reload low");
		rdc(ST, 8'h02, "status after write");
		rdc(30'h00FFE250, 8'h00, "unmapped");
		$display("test registers done");
		t_baud();
		t_diagnostic_select();
		t_flags();
		complete_run();
	end
endmodule : i2c_baud_status_test
